// ---- bench/dpg_sink.sv ----
module dpg_sink
  import dpg_pkg::*;
(
  input wire logic clock_i, // sample clock
  input wire logic signed [dpg_pkg::LVL_W-1:0] sample_i, // generator out
  output logic signed [dpg_pkg::LVL_W-1:0] seen_o // latched sample
);
  timeunit 1ns;
  timeprecision 1ns;
  // amplifier input takes one sample a clock, never back-pressures
  always_ff @(posedge clock_i) seen_o <= sample_i;
endmodule : dpg_sink

// ---- bench/dpg_top_props.sv ----
module dpg_chk
  import dpg_pkg::*;
(
  input wire logic clock_i, // clock
  input wire logic resetn_i, // reset
  input wire logic apply_i, // take
  input wire logic [dpg_pkg::TIME_W-1:0] delay_ns_i, // delay
  input wire logic signed [dpg_pkg::LVL_W-1:0] hi_mv_i, // high
  input wire logic [1:0] pol_i, // polarity
  input wire logic double_i, // double
  input wire logic [dpg_pkg::TIME_W-1:0] q_delay_ns_o, // held
  input wire logic [dpg_pkg::TIME_W-1:0] q_period_ns_o, // held
  input wire logic signed [dpg_pkg::LVL_W-1:0] q_hi_mv_o, // held
  input wire logic signed [dpg_pkg::LVL_W-1:0] q_lo_mv_o, // held
  input wire logic [1:0] q_pol_o, // held
  input wire logic q_double_o // held
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  a_delay_held: assert property (
    apply_i && delay_ns_i <= MAX_DELAY_NS |=>
    q_delay_ns_o == $past(delay_ns_i)) else $error("held delay");
  a_double_held: assert property (
    apply_i |=> q_double_o == $past(double_i)) else $error("held double");
  a_pol_held: assert property (
    apply_i && pol_i != 2'h3 |=> q_pol_o == $past(pol_i))
    else $error("held polarity");
  a_hi_clamp: assert property (
    apply_i && hi_mv_i > HI_MAX_MV |=> q_hi_mv_o == HI_MAX_MV)
    else $error("high not clamped");
  a_hi_range: assert property (
    q_hi_mv_o <= HI_MAX_MV && q_hi_mv_o >= HI_MIN_MV) else $error("high");
  a_lo_range: assert property (
    q_lo_mv_o <= LO_MAX_MV && q_lo_mv_o >= LO_MIN_MV) else $error("low");
  a_period_min: assert property (
    q_period_ns_o >= MIN_PERIOD_NS) else $error("period too short");
  a_held_stable: assert property (
    !apply_i |=> $stable(q_delay_ns_o) && $stable(q_pol_o))
    else $error("held value moved");
endmodule : dpg_chk
bind dpg_top dpg_chk i_dpg_chk(.clock_i, .resetn_i, .apply_i, .delay_ns_i,
  .hi_mv_i, .pol_i, .double_i, .q_delay_ns_o, .q_period_ns_o, .q_hi_mv_o,
  .q_lo_mv_o, .q_pol_o, .q_double_o);

// ---- bench/tb_top.sv ----
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("unexpected %0t: mismatch", $time); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dpg_pkg::*;
  localparam int P = 16;
  logic clock_i = 0, resetn_i = 0, apply_i = 0, dbl = 0, bigm = 0, busy, qdb;
  logic [63:0] dly = 0, spc = 0, hgh = 0, per = 0, qdl, qhg, qsp, qper;
  logic [63:0] rse = 0, fll = 0, qrs, qfl;
  logic signed [15:0] him = 0, lom = 0, smp, seen, qhi, qlo;
  logic [1:0] pl = 0, qpol;
  int fails = 0, cmp_count = 0, seed = 32'hdb5eb127;
  int d, h, s, hv, lv, i, k, r, u;
  int q[$];
  always #20 clock_i = ~clock_i;
  dpg_top i_dpg_top(.clock_i, .resetn_i, .apply_i, .delay_ns_i(dly),
    .space_ns_i(spc), .high_ns_i(hgh), .rise_ns_i(rse), .fall_ns_i(fll),
    .period_ns_i(per), .hi_mv_i(him), .lo_mv_i(lom), .pol_i(pl),
    .double_i(dbl), .big_memory_i(bigm), .sample_o(smp), .busy_o(busy),
    .q_delay_ns_o(qdl), .q_space_ns_o(qsp), .q_high_ns_o(qhg),
    .q_rise_ns_o(qrs), .q_fall_ns_o(qfl), .q_period_ns_o(qper),
    .q_hi_mv_o(qhi), .q_lo_mv_o(qlo), .q_pol_o(qpol), .q_double_o(qdb));
  dpg_sink i_dpg_sink(.clock_i, .sample_i(smp), .seen_o(seen));
  function automatic int pm(int x);
    return pl == 2'h1 ? hv + lv - x : pl == 2'h2 ? -x : x;
  endfunction : pm
  task final_report;
    $display("compares %0d fails %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task give_up;
    fails++;
    $display("unexpected %0t: wait ran out", $time);
    final_report;
  endtask : give_up
  // busy rises on the same edge as the take; one cycle is still skipped first
  task apply;
    apply_i = 1;
    @(negedge clock_i) apply_i = 0;
    @(negedge clock_i);
    for (i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clock_i);
    if (busy !== 1'b0) give_up;
  endtask : apply
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task run_case(input logic [1:0] p, input logic db);
    d = {$random(seed)} % 4;
    h = 1 + {$random(seed)} % 3;
    s = 1 + {$random(seed)} % 2;
    u = {$random(seed)} % 2;
    hv = {$random(seed)} % 4000 - 1000;
    lv = hv - 10 - {$random(seed)} % 900;
    dly = 64'(d * 40 + 15);
    hgh = 64'(h * 40 - 19);
    spc = 64'(s * 40 + 19);
    // a one-count ramp lands exactly on the far level in one sample
    {rse, fll} = {64'(u * 40), 64'(u * 40)};
    per = 64'(P * 40);
    {pl, dbl, him, lom, bigm} = {p, db, 16'(hv), 16'(lv), 1'($random(seed))};
    apply;
    `CHK(qdl, 64'(d * 40 + 15))
    `CHK(qpol, p)
    `CHK(qdb, db)
    `CHK(qhg, 64'(h * 40 - 19))
    `CHK(qsp, 64'(s * 40 + 19))
    `CHK(qrs, 64'(u * 40))
    `CHK(qfl, 64'(u * 40))
    `CHK(qhi, 16'(hv))
    `CHK(qlo, 16'(lv))
    q = {};
    for (k = 0; k < P; k++) q.push_back(lv);
    for (k = 0; k < h + u; k++) begin
      q[d + k] = hv;
      if (db) q[d + h + 2 * u + s + k] = hv;
    end
    repeat (P + 4) @(negedge clock_i);
    r = 0;
    for (i = 0; i < 200; i++) begin
      @(negedge clock_i);
      if (seen === 16'(pm(hv)) && r > s + u) break;
      r = seen === 16'(pm(lv)) ? r + 1 : 0;
    end
    if (i == 200) give_up;
    for (k = 1; k <= 2 * P; k++) begin
      @(negedge clock_i);
      `CHK(seen, 16'(pm(q[(d + k) % P])))
    end
    $display("test pol %0d double %0d done", p, db);
  endtask : run_case
  initial begin
    #(60000 * 40);
    give_up;
  end
  initial begin
    repeat (10) @(negedge clock_i);
    `CHK(qper, DEF_PERIOD_NS)
    `CHK(qdl, DEF_DELAY_NS)
    `CHK(qsp, DEF_SPACE_NS)
    `CHK(qhg, DEF_HIGH_NS)
    `CHK(qrs, DEF_RISE_NS)
    `CHK(qfl, DEF_FALL_NS)
    `CHK(qhi, DEF_HI_MV)
    `CHK(qlo, DEF_LO_MV)
    `CHK(qpol, POL_AS_PROGRAMMED)
    `CHK(qdb, DEF_DOUBLE)
    $display("test defaults done");
    resetn_i = 1;
    for (int c = 0; c < 6; c++) run_case(2'(c / 2), 1'(c % 2));
    {dly, him, lom, per} = {64'hFFFFFFFFFFFFFFFF, 16'sh1770, 16'sh2328, 64'h8};
    {rse, fll, pl} = {{2{64'hFFFFFFFFFFFFFFFF}}, 2'h3};
    apply;
    `CHK(qrs, MAX_LONG_NS)
    `CHK(qfl, MAX_LONG_NS)
    `CHK(qpol, 2'h3)
    `CHK(qdl, MAX_DELAY_NS)
    `CHK(qhi, HI_MAX_MV)
    `CHK(qlo, LO_MAX_MV)
    `CHK(qper, MIN_PERIOD_NS)
    {per, bigm} = {64'hFFFFFFFFFFFFFFFF, 1'b1};
    apply;
    `CHK(qper, MAX_PERIOD_BIG_NS)
    $display("test clamp done");
    final_report;
  end
endmodule : tb_top

// ---- logic/dpg_pkg.sv ----
// Overview of operation
// RULE_01: hold low for delay before rising edge
// RULE_02: controller keeps segment sum within period
// RULE_03: controller should program period first
// RULE_04: double mode emits identical second pulse
// RULE_05: double mode is one bit, default off
// RULE_06: spacing 0..1e3 s, default 2e-3, double only
// RULE_07: double mode keeps period unchanged
// RULE_08: second pulse uses same high level
// RULE_09: high dwell 0..1e3 s, default 1e-3
// RULE_10: high level -4.990..5 V, default 5
// RULE_11: controller keeps levels 10 mV apart
// RULE_12: low level -5..4.990 V, default 0
// RULE_13: period 80e-9..1e6 s, 2e6 big memory
// RULE_14: polarity normal, mirror zero, complement
// RULE_15: held timing values readable back
// RULE_16: polarity code readable back
// RULE_17: timing resolution one sample clock
// RULE_18: delay, rise, high, fall, low, repeat
// RULE_19: seconds rounded to nearest clock count
package dpg_pkg;

  localparam int TIME_W = 64;
  localparam int LVL_W = 16;
  localparam int FRAC_W = 16;
  localparam int ACC_W = 32;
  localparam int NCNT = 6;

  // ---------------------------------------------------------------
  // clock and time units
  // ---------------------------------------------------------------
  localparam longint CLK_HZ = 25_000_000;
  localparam logic [TIME_W-1:0] CLK_NS = TIME_W'(64'd1_000_000_000 / CLK_HZ);

  // held timing values are in nanoseconds
  localparam logic [TIME_W-1:0] DEF_DELAY_NS = 64'h0;
  localparam logic [TIME_W-1:0] DEF_SPACE_NS = 64'h1E8480;
  localparam logic [TIME_W-1:0] DEF_HIGH_NS = 64'hF4240;
  localparam logic [TIME_W-1:0] DEF_RISE_NS = 64'hF4240;
  localparam logic [TIME_W-1:0] DEF_FALL_NS = 64'hF4240;
  localparam logic [TIME_W-1:0] DEF_PERIOD_NS = 64'h989680;
  localparam logic [TIME_W-1:0] MAX_DELAY_NS = 64'h2540BE400;
  localparam logic [TIME_W-1:0] MAX_LONG_NS = 64'hE8D4A51000;
  localparam logic [TIME_W-1:0] MIN_PERIOD_NS = 64'h50;
  localparam logic [TIME_W-1:0] MAX_PERIOD_NS = 64'h38D7EA4C68000;
  localparam logic [TIME_W-1:0] MAX_PERIOD_BIG_NS = 64'h71AFD498D0000;

  // ---------------------------------------------------------------
  // levels in millivolts, signed
  // ---------------------------------------------------------------
  localparam logic signed [LVL_W-1:0] DEF_HI_MV = 16'sh1388;
  localparam logic signed [LVL_W-1:0] DEF_LO_MV = 16'sh0000;
  localparam logic signed [LVL_W-1:0] HI_MAX_MV = 16'sh1388;
  localparam logic signed [LVL_W-1:0] HI_MIN_MV = -16'sh137E;
  localparam logic signed [LVL_W-1:0] LO_MAX_MV = 16'sh137E;
  localparam logic signed [LVL_W-1:0] LO_MIN_MV = -16'sh1388;

  // ---------------------------------------------------------------
  // codes and indices
  // ---------------------------------------------------------------
  localparam logic [1:0] POL_AS_PROGRAMMED = 2'h0;
  localparam logic [1:0] POL_COMPLEMENT = 2'h1;
  localparam logic [1:0] POL_MIRROR_ZERO = 2'h2;
  localparam logic DEF_DOUBLE = 1'b0;

  localparam logic [2:0] IDX_DELAY = 3'h0;
  localparam logic [2:0] IDX_SPACE = 3'h1;
  localparam logic [2:0] IDX_HIGH = 3'h2;
  localparam logic [2:0] IDX_RISE = 3'h3;
  localparam logic [2:0] IDX_FALL = 3'h4;
  localparam logic [2:0] IDX_PERIOD = 3'h5;
  localparam logic [2:0] IDX_RSTEP = 3'h6;
  localparam logic [2:0] IDX_FSTEP = 3'h7;

  typedef enum logic [2:0] {
    SEG_WAIT, SEG_DELAY, SEG_RISE, SEG_HIGH, SEG_FALL, SEG_GAP, SEG_TAIL
  } dpg_seg_t;

  function automatic logic [TIME_W-1:0] dpg_clamp_u(
      input logic [TIME_W-1:0] v, input logic [TIME_W-1:0] lo,
      input logic [TIME_W-1:0] hi);
    dpg_clamp_u = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : dpg_clamp_u

  function automatic logic signed [LVL_W-1:0] dpg_clamp_s(
      input logic signed [LVL_W-1:0] v, input logic signed [LVL_W-1:0] lo,
      input logic signed [LVL_W-1:0] hi);
    dpg_clamp_s = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : dpg_clamp_s

endpackage : dpg_pkg

// ---- logic/dpg_rdiv.sv ----
// ---------------------------------------------------------------
// sequential divider, quotient rounded to nearest
// ---------------------------------------------------------------
module dpg_rdiv #(
  parameter int W = 64
) (
  input wire logic clock_i,          // sample clock
  input wire logic resetn_i,         // sync reset, active low
  input wire logic start_i,          // begin a division
  input wire logic [W-1:0] num_i,    // dividend
  input wire logic [W-1:0] den_i,    // divisor
  output logic [W-1:0] quo_o,        // rounded quotient
  output logic done_o                // quotient valid pulse
);
  localparam int CW = $clog2(W + 1);

  logic [W:0] rem_reg, rem_next;
  logic [W-1:0] quo_reg, quo_next, den_reg, den_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next, done_reg, done_next;
  logic [W:0] shifted;

  always_comb begin
    rem_next = rem_reg;
    quo_next = quo_reg;
    den_next = den_reg;
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    shifted = {rem_reg[W-1:0], quo_reg[W-1]};
    if (start_i) begin
      // half the divisor added first gives round to nearest
      quo_next = num_i + (den_i >> 1); // see RULE_19
      rem_next = '0;
      den_next = den_i;
      cnt_next = CW'(W);
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (shifted >= {1'b0, den_reg}) begin
        rem_next = shifted - {1'b0, den_reg};
        quo_next = {quo_reg[W-2:0], 1'b1};
      end else begin
        rem_next = shifted;
        quo_next = {quo_reg[W-2:0], 1'b0};
      end
      cnt_next = cnt_reg - CW'(1);
      if (cnt_reg == CW'(1)) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rem_reg <= '0;
      quo_reg <= '0;
      den_reg <= '0;
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      rem_reg <= rem_next;
      quo_reg <= quo_next;
      den_reg <= den_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign quo_o = quo_reg;
  assign done_o = done_reg;
endmodule : dpg_rdiv

// ---- logic/dpg_shape.sv ----
// ---------------------------------------------------------------
// polarity mapping onto the output sample
// ---------------------------------------------------------------
module dpg_shape
  import dpg_pkg::*;
(
  input wire logic clock_i,                        // sample clock
  input wire logic resetn_i,                       // sync reset, low
  input wire logic signed [dpg_pkg::LVL_W-1:0] level_i, // raw level
  input wire logic signed [dpg_pkg::LVL_W-1:0] high_i,  // high level
  input wire logic signed [dpg_pkg::LVL_W-1:0] low_i,   // low level
  input wire logic [1:0] pol_i,                    // polarity code
  output logic signed [dpg_pkg::LVL_W-1:0] sample_o     // output sample
);
  logic signed [LVL_W-1:0] sample_reg, sample_next;
  logic signed [LVL_W:0] mid_sum;

  always_comb begin
    mid_sum = (LVL_W+1)'(high_i) + (LVL_W+1)'(low_i)
            - (LVL_W+1)'(level_i);
    case (pol_i)
      POL_COMPLEMENT: sample_next = LVL_W'(mid_sum); // see RULE_14
      POL_MIRROR_ZERO: sample_next = -level_i;       // see RULE_14
      default: sample_next = level_i;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      sample_reg <= '0;
    end else begin
      sample_reg <= sample_next;
    end
  end

  assign sample_o = sample_reg;
endmodule : dpg_shape

// ---- logic/dpg_top.sv ----
module dpg_top
  import dpg_pkg::*;
(
  input wire logic clock_i,                          // 25 MHz clock
  input wire logic resetn_i,                         // sync, active low
  input wire logic apply_i,                          // take settings
  input wire logic [dpg_pkg::TIME_W-1:0] delay_ns_i, // start delay
  input wire logic [dpg_pkg::TIME_W-1:0] space_ns_i, // double spacing
  input wire logic [dpg_pkg::TIME_W-1:0] high_ns_i,  // high dwell
  input wire logic [dpg_pkg::TIME_W-1:0] rise_ns_i,  // rise time
  input wire logic [dpg_pkg::TIME_W-1:0] fall_ns_i,  // fall time
  input wire logic [dpg_pkg::TIME_W-1:0] period_ns_i, // period
  input wire logic signed [dpg_pkg::LVL_W-1:0] hi_mv_i, // high level
  input wire logic signed [dpg_pkg::LVL_W-1:0] lo_mv_i, // low level
  input wire logic [1:0] pol_i,                      // polarity code
  input wire logic double_i,                         // double pulse on
  input wire logic big_memory_i,                     // long period option
  output logic signed [dpg_pkg::LVL_W-1:0] sample_o, // waveform sample
  output logic busy_o,                               // converting
  output logic [dpg_pkg::TIME_W-1:0] q_delay_ns_o,   // held delay
  output logic [dpg_pkg::TIME_W-1:0] q_space_ns_o,   // held spacing
  output logic [dpg_pkg::TIME_W-1:0] q_high_ns_o,    // held dwell
  output logic [dpg_pkg::TIME_W-1:0] q_rise_ns_o,    // held rise
  output logic [dpg_pkg::TIME_W-1:0] q_fall_ns_o,    // held fall
  output logic [dpg_pkg::TIME_W-1:0] q_period_ns_o,  // held period
  output logic signed [dpg_pkg::LVL_W-1:0] q_hi_mv_o, // held high
  output logic signed [dpg_pkg::LVL_W-1:0] q_lo_mv_o, // held low
  output logic [1:0] q_pol_o,                        // held polarity
  output logic q_double_o                            // held double
);
  import dpg_pkg::*;

  typedef logic [NCNT-1:0][TIME_W-1:0] dpg_cnts_t;

  // ---------------------------------------------------------------
  // held settings
  // ---------------------------------------------------------------
  dpg_cnts_t hold_reg, hold_next;
  logic signed [LVL_W-1:0] hold_hi_reg, hold_hi_next;
  logic signed [LVL_W-1:0] hold_lo_reg, hold_lo_next;
  logic [1:0] hold_pol_reg, hold_pol_next;
  logic hold_dbl_reg, hold_dbl_next;
  logic [TIME_W-1:0] per_max;

  always_comb begin
    hold_next = hold_reg;
    hold_hi_next = hold_hi_reg;
    hold_lo_next = hold_lo_reg;
    hold_pol_next = hold_pol_reg;
    hold_dbl_next = hold_dbl_reg;
    per_max = big_memory_i ? MAX_PERIOD_BIG_NS : MAX_PERIOD_NS;
    if (apply_i) begin
      hold_next[IDX_DELAY] = dpg_clamp_u(delay_ns_i, '0,
                                         MAX_DELAY_NS); // see RULE_01
      hold_next[IDX_SPACE] = dpg_clamp_u(space_ns_i, '0,
                                         MAX_LONG_NS); // see RULE_06
      hold_next[IDX_HIGH] = dpg_clamp_u(high_ns_i, '0,
                                        MAX_LONG_NS); // see RULE_09
      hold_next[IDX_RISE] = dpg_clamp_u(rise_ns_i, '0, MAX_LONG_NS);
      hold_next[IDX_FALL] = dpg_clamp_u(fall_ns_i, '0, MAX_LONG_NS);
      hold_next[IDX_PERIOD] = dpg_clamp_u(period_ns_i, MIN_PERIOD_NS,
                                          per_max); // see RULE_13
      hold_hi_next = dpg_clamp_s(hi_mv_i, HI_MIN_MV,
                                 HI_MAX_MV); // see RULE_10
      hold_lo_next = dpg_clamp_s(lo_mv_i, LO_MIN_MV,
                                 LO_MAX_MV); // see RULE_12
      hold_pol_next = pol_i;
      hold_dbl_next = double_i; // see RULE_05
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      hold_reg[IDX_DELAY] <= DEF_DELAY_NS;
      hold_reg[IDX_SPACE] <= DEF_SPACE_NS;
      hold_reg[IDX_HIGH] <= DEF_HIGH_NS;
      hold_reg[IDX_RISE] <= DEF_RISE_NS;
      hold_reg[IDX_FALL] <= DEF_FALL_NS;
      hold_reg[IDX_PERIOD] <= DEF_PERIOD_NS;
      hold_hi_reg <= DEF_HI_MV;
      hold_lo_reg <= DEF_LO_MV;
      hold_pol_reg <= POL_AS_PROGRAMMED;
      hold_dbl_reg <= DEF_DOUBLE;
    end else begin
      hold_reg <= hold_next;
      hold_hi_reg <= hold_hi_next;
      hold_lo_reg <= hold_lo_next;
      hold_pol_reg <= hold_pol_next;
      hold_dbl_reg <= hold_dbl_next;
    end
  end

  // ---------------------------------------------------------------
  // conversion to clock counts and ramp steps
  // ---------------------------------------------------------------
  // one shared divider costs eight divisions per update, far less
  // area than a divider per setting
  dpg_cnts_t new_reg, new_next;
  logic [ACC_W-1:0] new_rstep_reg, new_rstep_next;
  logic [ACC_W-1:0] new_fstep_reg, new_fstep_next;
  logic [2:0] cv_idx_reg, cv_idx_next;
  logic cv_busy_reg, cv_busy_next, cv_start_reg, cv_start_next;
  logic pend_reg, pend_next, cv_fin, load;
  logic [TIME_W-1:0] div_num, div_den, div_quo;
  logic div_done;
  logic signed [LVL_W:0] swing;

  always_comb begin
    swing = (LVL_W+1)'(hold_hi_reg) - (LVL_W+1)'(hold_lo_reg);
    if (cv_idx_reg == IDX_RSTEP || cv_idx_reg == IDX_FSTEP) begin
      div_num = (swing > 0) ? (TIME_W'(swing) << FRAC_W) : '0;
      div_den = (cv_idx_reg == IDX_RSTEP) ? new_reg[IDX_RISE]
                                          : new_reg[IDX_FALL];
    end else begin
      div_num = hold_reg[cv_idx_reg];
      div_den = CLK_NS; // see RULE_17
    end
  end

  dpg_rdiv #(.W(TIME_W)) u_div (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .start_i(cv_start_reg),
    .num_i(div_num),
    .den_i(div_den),
    .quo_o(div_quo),
    .done_o(div_done)
  );

  always_comb begin
    new_next = new_reg;
    new_rstep_next = new_rstep_reg;
    new_fstep_next = new_fstep_reg;
    cv_idx_next = cv_idx_reg;
    cv_busy_next = cv_busy_reg;
    cv_start_next = 1'b0;
    cv_fin = 1'b0;
    if (apply_i) begin
      cv_idx_next = IDX_DELAY;
      cv_busy_next = 1'b1;
      cv_start_next = 1'b1;
    end else if (cv_busy_reg && div_done) begin
      if (cv_idx_reg == IDX_RSTEP) begin
        new_rstep_next = div_quo[ACC_W-1:0];
      end else if (cv_idx_reg == IDX_FSTEP) begin
        new_fstep_next = div_quo[ACC_W-1:0];
      end else begin
        new_next[cv_idx_reg] = div_quo; // see RULE_19
      end
      if (cv_idx_reg == IDX_FSTEP) begin
        cv_busy_next = 1'b0;
        cv_fin = 1'b1;
      end else begin
        cv_idx_next = cv_idx_reg + 3'h1;
        cv_start_next = 1'b1;
      end
    end
    // a finished set wins over its own consumption
    if (apply_i) begin
      pend_next = 1'b0;
    end else if (cv_fin) begin
      pend_next = 1'b1;
    end else if (load) begin
      pend_next = 1'b0;
    end else begin
      pend_next = pend_reg;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      new_reg <= '0;
      new_rstep_reg <= '0;
      new_fstep_reg <= '0;
      cv_idx_reg <= IDX_DELAY;
      cv_busy_reg <= 1'b1;
      cv_start_reg <= 1'b1;
      pend_reg <= 1'b0;
    end else begin
      new_reg <= new_next;
      new_rstep_reg <= new_rstep_next;
      new_fstep_reg <= new_fstep_next;
      cv_idx_reg <= cv_idx_next;
      cv_busy_reg <= cv_busy_next;
      cv_start_reg <= cv_start_next;
      pend_reg <= pend_next;
    end
  end

  // ---------------------------------------------------------------
  // segment sequencer
  // ---------------------------------------------------------------
  dpg_cnts_t act_reg, act_next, use_cnt;
  logic [ACC_W-1:0] act_rstep_reg, act_rstep_next, rstep, fstep;
  logic [ACC_W-1:0] act_fstep_reg, act_fstep_next;
  logic signed [LVL_W-1:0] act_hi_reg, act_hi_next, use_hi;
  logic signed [LVL_W-1:0] act_lo_reg, act_lo_next, use_lo;
  logic [1:0] act_pol_reg, act_pol_next;
  logic act_dbl_reg, act_dbl_next, use_dbl;
  dpg_seg_t seg_reg, seg_next;
  logic second_reg, second_next;
  logic [TIME_W-1:0] seg_cnt_reg, seg_cnt_next;
  logic [TIME_W-1:0] per_cnt_reg, per_cnt_next;
  logic signed [ACC_W-1:0] acc_reg, acc_next, hi_fx, lo_fx, lvl_fx;
  logic per_end, enter, advance;

  function automatic logic [TIME_W-1:0] seg_len(input dpg_seg_t s,
                                                input dpg_cnts_t c);
    case (s)
      SEG_DELAY: seg_len = c[IDX_DELAY];
      SEG_RISE: seg_len = c[IDX_RISE];
      SEG_HIGH: seg_len = c[IDX_HIGH];
      SEG_FALL: seg_len = c[IDX_FALL];
      SEG_GAP: seg_len = c[IDX_SPACE];
      default: seg_len = '1;
    endcase
  endfunction : seg_len

  always_comb begin
    act_next = act_reg;
    act_rstep_next = act_rstep_reg;
    act_fstep_next = act_fstep_reg;
    act_hi_next = act_hi_reg;
    act_lo_next = act_lo_reg;
    act_pol_next = act_pol_reg;
    act_dbl_next = act_dbl_reg;
    seg_next = seg_reg;
    second_next = second_reg;
    seg_cnt_next = seg_cnt_reg + TIME_W'(1);
    per_cnt_next = per_cnt_reg + TIME_W'(1);
    // period length is untouched by double mode
    per_end = (seg_reg != SEG_WAIT)
            && (per_cnt_reg == act_reg[IDX_PERIOD] - TIME_W'(1));
    // see RULE_07
    // new settings take effect on a period boundary, or at once while still in SEG_WAIT after reset
    load = pend_reg && !cv_busy_reg && (per_end || seg_reg == SEG_WAIT);
    enter = load || per_end;
    use_cnt = load ? new_reg : act_reg;
    use_hi = load ? hold_hi_reg : act_hi_reg;
    use_lo = load ? hold_lo_reg : act_lo_reg;
    use_dbl = load ? hold_dbl_reg : act_dbl_reg;
    rstep = load ? new_rstep_reg : act_rstep_reg;
    fstep = load ? new_fstep_reg : act_fstep_reg;
    if (load) begin
      act_next = new_reg;
      act_rstep_next = new_rstep_reg;
      act_fstep_next = new_fstep_reg;
      act_hi_next = hold_hi_reg;
      act_lo_next = hold_lo_reg;
      act_pol_next = hold_pol_reg;
      act_dbl_next = hold_dbl_reg;
    end
    advance = (seg_reg != SEG_WAIT) && (seg_reg != SEG_TAIL)
            && (seg_cnt_reg + TIME_W'(1) >= seg_len(seg_reg, use_cnt));
    if (enter) begin
      seg_next = SEG_DELAY; // see RULE_01
      second_next = 1'b0;
      per_cnt_next = '0;
    end else if (seg_reg == SEG_WAIT) begin
      per_cnt_next = '0;
    end
    // zero-length segments are skipped in the same cycle
    for (int i = 0; i < NCNT; i++) begin
      if (advance || (seg_next != seg_reg
                      && seg_next != SEG_WAIT && seg_next != SEG_TAIL
                      && seg_len(seg_next, use_cnt) == '0)) begin
        advance = 1'b0;
        case (seg_next)
          SEG_DELAY: seg_next = SEG_RISE; // see RULE_18
          SEG_RISE: seg_next = SEG_HIGH;
          SEG_HIGH: seg_next = SEG_FALL;
          SEG_FALL: begin
            // spacing matters only when the mode is on
            if (use_dbl && !second_next) begin
              seg_next = SEG_GAP; // see RULE_06
            end else begin
              seg_next = SEG_TAIL;
            end
          end
          SEG_GAP: begin
            seg_next = SEG_RISE; // see RULE_04
            second_next = 1'b1;
          end
          default: seg_next = SEG_TAIL;
        endcase
      end
    end
    if (seg_next != seg_reg || enter) begin
      seg_cnt_next = '0;
    end
    // ramp level in fixed point; same levels for both pulses
    hi_fx = ACC_W'(use_hi) <<< FRAC_W; // see RULE_08
    lo_fx = ACC_W'(use_lo) <<< FRAC_W;
    case (seg_next)
      SEG_RISE: begin
        acc_next = ((seg_cnt_next == '0) ? lo_fx : acc_reg)
                 + $signed(rstep);
        if (acc_next > hi_fx) begin
          acc_next = hi_fx;
        end
      end
      SEG_HIGH: acc_next = hi_fx; // see RULE_09
      SEG_FALL: begin
        acc_next = ((seg_cnt_next == '0) ? hi_fx : acc_reg)
                 - $signed(fstep);
        if (acc_next < lo_fx) begin
          acc_next = lo_fx;
        end
      end
      default: acc_next = lo_fx;
    endcase
    lvl_fx = acc_reg + (ACC_W'(1) <<< (FRAC_W - 1));
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      act_reg <= '0;
      act_rstep_reg <= '0;
      act_fstep_reg <= '0;
      act_hi_reg <= DEF_HI_MV;
      act_lo_reg <= DEF_LO_MV;
      act_pol_reg <= POL_AS_PROGRAMMED;
      act_dbl_reg <= DEF_DOUBLE;
      seg_reg <= SEG_WAIT;
      second_reg <= 1'b0;
      seg_cnt_reg <= '0;
      per_cnt_reg <= '0;
      acc_reg <= '0;
    end else begin
      act_reg <= act_next;
      act_rstep_reg <= act_rstep_next;
      act_fstep_reg <= act_fstep_next;
      act_hi_reg <= act_hi_next;
      act_lo_reg <= act_lo_next;
      act_pol_reg <= act_pol_next;
      act_dbl_reg <= act_dbl_next;
      seg_reg <= seg_next;
      second_reg <= second_next;
      seg_cnt_reg <= seg_cnt_next;
      per_cnt_reg <= per_cnt_next;
      acc_reg <= acc_next;
    end
  end

  dpg_shape u_shape (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .level_i(LVL_W'(lvl_fx >>> FRAC_W)),
    .high_i(act_hi_reg),
    .low_i(act_lo_reg),
    .pol_i(act_pol_reg),
    .sample_o(sample_o)
  );

  // ---------------------------------------------------------------
  // readback
  // ---------------------------------------------------------------
  assign busy_o = cv_busy_reg;
  assign q_delay_ns_o = hold_reg[IDX_DELAY]; // see RULE_15
  assign q_space_ns_o = hold_reg[IDX_SPACE];
  assign q_high_ns_o = hold_reg[IDX_HIGH];
  assign q_rise_ns_o = hold_reg[IDX_RISE];
  assign q_fall_ns_o = hold_reg[IDX_FALL];
  assign q_period_ns_o = hold_reg[IDX_PERIOD];
  assign q_hi_mv_o = hold_hi_reg;
  assign q_lo_mv_o = hold_lo_reg;
  assign q_pol_o = hold_pol_reg; // see RULE_16
  assign q_double_o = hold_dbl_reg;
endmodule : dpg_top
